// ### src/cif_pkg.sv
// Constants, field positions and types shared by the CAN identifier filter block.
// Assumes the protocol engine, CPU mode logic and sleep sequencer sit outside.
package cif_pkg;

  // ==========================================================================
  // operating modes and filter organisation
  // ==========================================================================
  typedef enum logic [1:0] {
    CIF_NORMAL,
    CIF_SLEEP,
    CIF_SOFT_RESET,
    CIF_POWER_DOWN
  } cif_mode_e;

  localparam logic [1:0] FMODE_SINGLE = 2'h0;
  localparam logic [1:0] FMODE_DUAL = 2'h1;
  localparam logic [1:0] FMODE_QUAD = 2'h2;
  localparam logic [1:0] FMODE_CLOSED = 2'h3;

  // ==========================================================================
  // configuration store, reached by index
  // ==========================================================================
  localparam int CFG_COUNT = 12;
  localparam logic [3:0] CFG_MODULE_CTRL_ONE = 4'h0;
  localparam logic [3:0] CFG_BIT_TIMING_ZERO = 4'h1;
  localparam logic [3:0] CFG_BIT_TIMING_ONE = 4'h2;
  localparam logic [3:0] CFG_FILTER_CONTROL = 4'h3;
  localparam logic [3:0] CFG_PATTERN_BASE = 4'h4;
  localparam logic [3:0] CFG_DONTCARE_BASE = 4'h8;
  localparam logic [7:0] CFG_RESET_VALUE = 8'h00;

  // field positions
  localparam int FCTL_MODE_LSB = 4;
  localparam int LOOPBACK_BIT = 5;

  // ==========================================================================
  // receiver flag register layout
  // ==========================================================================
  localparam int RFLG_WAKE = 7;
  localparam int RFLG_RX_WARN = 6;
  localparam int RFLG_TX_WARN = 5;
  localparam int RFLG_RX_PASSIVE = 4;
  localparam int RFLG_TX_PASSIVE = 3;
  localparam int RFLG_BUS_OFF = 2;
  localparam int RFLG_OVERRUN = 1;
  localparam int RFLG_RX_FULL = 0;
  localparam logic [7:0] RFLG_RESET = 8'h00;
  localparam logic [2:0] TFLG_RESET = 3'h7;

  // ==========================================================================
  // error counter limits
  // ==========================================================================
  localparam int ERR_CNT_W = 9;
  localparam logic [ERR_CNT_W-1:0] WARN_LIMIT = 9'h060;
  localparam logic [ERR_CNT_W-1:0] PASSIVE_LIMIT = 9'h07F;
  localparam logic [ERR_CNT_W-1:0] BUS_OFF_LIMIT = 9'h0FF;

  localparam logic RECESSIVE = 1'b1;
  localparam int ID_W = 32;

endpackage : cif_pkg

// ### src/cif_byte_match.sv
// One maskable compare slice of the acceptance filter bank.
// Assumes pattern and don't-care come from configuration flip-flops.
`timescale 1ns/10ps
module cif_byte_match #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pattern,
  input wire logic [W-1:0] dontcare,
  input wire logic [W-1:0] id,
  output logic hit
);
  // a set don't-care bit forces that position to match
  assign hit = &(~(pattern ^ id) | dontcare);
endmodule : cif_byte_match

// ### src/cif_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; clk_en low freezes every pointer and word.
`timescale 1ns/10ps
module cif_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  wire push = in_valid && in_ready && clk_en;
  wire pop = out_valid && out_ready && clk_en;

  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // storage needs no reset: out_valid guards every word read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : cif_fifo

// ### src/cif_can_id_filter.sv
// Identifier acceptance filter, receive staging, flag and vector logic, config
// lock and low-power mode decode of a CAN controller.
// Assumes a protocol engine delivers each valid frame after end-of-frame and
// supplies error counters, transmit completions, bus activity and the tx bit.
//
// Summary of operation
// - compare identifier to pattern bits; set don't-care bits always match
// - record two-bit hit index; lowest-numbered matching filter wins
// - single mode: one 32-bit filter over full identifier field
// - dual mode: two 16-bit filters over the leading identifier bits
// - quad mode: four 8-bit filters on the first identifier byte
// - closed mode: nothing reaches the front buffer, receive-full never set
// - four vectors from eleven sources, each locally enabled, globally masked
// - transmit buffer not scheduled shows empty flag, requests transmit vector
// - accepted message in front buffer sets receive-full right after frame
// - bus activity in sleep/power-down sets wake flag; irq needs ack and enable
// - warning flags set when an error counter reaches 96
// - passive state and flags when a counter exceeds 127
// - bus-off state and flag when transmit counter exceeds 255
// - overrun flag belongs to the error vector group
// - accepted message with both buffers full is dropped, overrun flagged
// - back buffer moves to front only while receive-full is clear
// - vector stays pending while any enabled flag of its group is set; wake also needs sleep ack
// - writing one clears a flag, writing zero leaves it
// - clear is ignored while the setting condition persists
// - error counters cannot be written by software
// - configuration writes take effect only with soft reset lock set
// - transmit pin recessive in sleep, soft reset and power-down
// - sleep/soft reset keep register clocks only; power-down stops all
// - mode decode: stop gives power-down, else sleep-ack/soft-reset pair
`timescale 1ns/10ps
module cif_can_id_filter
  import cif_pkg::*;
#(
  parameter int DATA_W = 64,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // frames from the protocol engine
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire logic [ID_W-1:0] rx_in_id,
  input wire logic [DATA_W-1:0] rx_in_data,
  input wire logic rx_in_own,
  // front buffer as software sees it
  output logic [ID_W-1:0] rx_front_id,
  output logic [DATA_W-1:0] rx_front_data,
  output logic [1:0] filter_hit_index,
  // mode inputs
  input wire logic cpu_stop,
  input wire logic sleep_ack,
  input wire logic soft_reset_lock,
  input wire logic global_irq_mask,
  input wire logic bus_activity,
  // error counters, owned by the protocol engine
  input wire logic [ERR_CNT_W-1:0] rx_err_cnt,
  input wire logic [ERR_CNT_W-1:0] tx_err_cnt,
  // transmit buffers
  input wire logic [2:0] tx_done,
  input wire logic [2:0] tx_flag_clr,
  input wire logic tx_bit,
  output logic can_tx_pin,
  // configuration writes
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_sel,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] module_ctrl_one,
  output logic [7:0] bit_timing_zero,
  output logic [7:0] bit_timing_one,
  output logic [7:0] filter_control_reg,
  output logic [ID_W-1:0] id_pattern_regs,
  output logic [ID_W-1:0] id_dontcare_regs,
  // receiver flags
  input wire logic rx_flag_clr_wr,
  input wire logic [7:0] rx_flag_clr_data,
  output logic [7:0] rx_flag_reg,
  output logic [2:0] tx_flag_reg,
  // local enables
  input wire logic wake_irq_en,
  input wire logic [5:0] err_irq_en,
  input wire logic rx_full_irq_en,
  input wire logic [2:0] tx_empty_irq_en,
  // vectors and status
  output logic irq_wake,
  output logic irq_err,
  output logic irq_rx,
  output logic irq_tx,
  output cif_mode_e can_mode,
  output logic core_clk_run,
  output logic reg_clk_run,
  output logic rx_passive_state,
  output logic tx_passive_state,
  output logic bus_off_state
);

  localparam int WORD_W = DATA_W + ID_W + 1;

  // ==========================================================================
  // mode decode
  // ==========================================================================
  cif_mode_e mode;
  always_comb begin
    if (cpu_stop) begin
      mode = CIF_POWER_DOWN;
    end else if (soft_reset_lock) begin
      mode = CIF_SOFT_RESET;
    end else if (sleep_ack) begin
      mode = CIF_SLEEP;
    end else begin
      mode = CIF_NORMAL;
    end
  end
  assign can_mode = mode;

  // the core only advances in normal mode; registers stay reachable unless
  // powered down
  wire core_run = (mode == CIF_NORMAL);
  wire reg_run = (mode != CIF_POWER_DOWN);
  assign core_clk_run = core_run;
  assign reg_clk_run = reg_run;
  wire core_step = core_run && clk_en;
  wire reg_step = reg_run && clk_en;

  // ==========================================================================
  // configuration store
  // ==========================================================================
  logic [7:0] cfg_mem [CFG_COUNT];
  wire cfg_take = cfg_wr && soft_reset_lock && reg_step;
  wire cfg_sel_ok = (cfg_sel < 4'(CFG_COUNT));

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < CFG_COUNT; i++) begin
        cfg_mem[i] <= CFG_RESET_VALUE;
      end
    end else if (cfg_take && cfg_sel_ok) begin
      cfg_mem[cfg_sel] <= cfg_wdata;
    end
  end

  wire [1:0] fmode = cfg_mem[CFG_FILTER_CONTROL][FCTL_MODE_LSB +: 2];
  wire loopback = cfg_mem[CFG_MODULE_CTRL_ONE][LOOPBACK_BIT];
  logic [1:0] front_hit;

  assign module_ctrl_one = cfg_mem[CFG_MODULE_CTRL_ONE];
  assign bit_timing_zero = cfg_mem[CFG_BIT_TIMING_ZERO];
  assign bit_timing_one = cfg_mem[CFG_BIT_TIMING_ONE];
  assign filter_control_reg = {2'h0, fmode, 2'h0, front_hit};
  assign filter_hit_index = front_hit;

  // ==========================================================================
  // frame FIFO
  // ==========================================================================
  logic f_valid;
  logic [WORD_W-1:0] f_word;

  // draining stops outside normal mode, so the engine sees back-pressure
  cif_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data({rx_in_own, rx_in_data, rx_in_id}),
    .out_valid(f_valid),
    .out_ready(core_run),
    .out_data(f_word)
  );

  wire [ID_W-1:0] f_id = f_word[ID_W-1:0];
  wire [DATA_W-1:0] f_data = f_word[ID_W +: DATA_W];
  wire f_own = f_word[WORD_W-1];
  wire f_pop = f_valid && core_step;

  // ==========================================================================
  // acceptance filter bank
  // ==========================================================================
  // byte k of the bank is byte k of the identifier field, first-sent first
  logic [3:0] m_dir;
  logic [3:0] m_dual;
  logic [3:0] m_quad;

  for (genvar k = 0; k < 4; k++) begin : g_slice
    wire [7:0] pat = cfg_mem[CFG_PATTERN_BASE + 4'(k)];
    wire [7:0] dc = cfg_mem[CFG_DONTCARE_BASE + 4'(k)];
    assign id_pattern_regs[ID_W-1-8*k -: 8] = pat;
    assign id_dontcare_regs[ID_W-1-8*k -: 8] = dc;
    cif_byte_match #(.W(8)) u_dir (
      .pattern(pat),
      .dontcare(dc),
      .id(f_id[ID_W-1-8*k -: 8]),
      .hit(m_dir[k])
    );
    cif_byte_match #(.W(8)) u_dual (
      .pattern(pat),
      .dontcare(dc),
      .id(f_id[ID_W-1-8*(k%2) -: 8]),
      .hit(m_dual[k])
    );
    cif_byte_match #(.W(8)) u_quad (
      .pattern(pat),
      .dontcare(dc),
      .id(f_id[ID_W-1 -: 8]),
      .hit(m_quad[k])
    );
  end

  logic [3:0] hits;
  always_comb begin
    unique case (fmode)
      FMODE_SINGLE: hits = {3'h0, &m_dir};
      FMODE_DUAL: hits = {2'h0, &m_dual[3:2], &m_dual[1:0]};
      FMODE_QUAD: hits = m_quad;
      FMODE_CLOSED: hits = 4'h0;
    endcase
  end

  // lowest filter number wins when several match
  wire [1:0] hit_idx = hits[0] ? 2'h0 : hits[1] ? 2'h1 : hits[2] ? 2'h2 : 2'h3;

  // own frames only count in loopback
  wire accept = f_pop && (|hits) && (!f_own || loopback);

  // ==========================================================================
  // two-stage receive buffer
  // ==========================================================================
  logic back_full;
  logic [ID_W-1:0] back_id;
  logic [DATA_W-1:0] back_data;
  logic [1:0] back_hit;

  wire rx_full = rx_flag_reg[RFLG_RX_FULL];
  wire copy = back_full && !rx_full && core_step;
  wire load_back = accept && (!back_full || copy);
  wire overrun_ev = accept && back_full && !copy;

  always_ff @(posedge clk) begin
    if (reset) begin
      back_full <= 1'b0;
    end else if (load_back) begin
      back_full <= 1'b1;
    end else if (copy) begin
      back_full <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      back_id <= '0;
      back_data <= '0;
      back_hit <= 2'h0;
    end else if (load_back) begin
      back_id <= f_id;
      back_data <= f_data;
      back_hit <= hit_idx;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_front_id <= '0;
      rx_front_data <= '0;
      front_hit <= 2'h0;
    end else if (copy) begin
      rx_front_id <= back_id;
      rx_front_data <= back_data;
      front_hit <= back_hit;
    end
  end

  // ==========================================================================
  // error state from the counters
  // ==========================================================================
  // the counters arrive only as inputs; no path here can alter them
  wire rx_warn_c = (rx_err_cnt >= WARN_LIMIT);
  wire tx_warn_c = (tx_err_cnt >= WARN_LIMIT);
  wire rx_pass_c = (rx_err_cnt > PASSIVE_LIMIT);
  wire tx_pass_c = (tx_err_cnt > PASSIVE_LIMIT);
  wire boff_c = (tx_err_cnt > BUS_OFF_LIMIT);

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_passive_state <= 1'b0;
      tx_passive_state <= 1'b0;
      bus_off_state <= 1'b0;
    end else if (clk_en) begin
      rx_passive_state <= rx_pass_c;
      tx_passive_state <= tx_pass_c;
      bus_off_state <= boff_c;
    end
  end

  // ==========================================================================
  // receiver and transmitter flags
  // ==========================================================================
  wire wake_ev = bus_activity && (mode == CIF_SLEEP || mode == CIF_POWER_DOWN);

  logic [7:0] rset;
  logic [7:0] rhold;
  always_comb begin
    rset = 8'h00;
    rset[RFLG_WAKE] = wake_ev;
    rset[RFLG_RX_WARN] = rx_warn_c;
    rset[RFLG_TX_WARN] = tx_warn_c;
    rset[RFLG_RX_PASSIVE] = rx_pass_c;
    rset[RFLG_TX_PASSIVE] = tx_pass_c;
    rset[RFLG_BUS_OFF] = boff_c;
    rset[RFLG_OVERRUN] = overrun_ev;
    rset[RFLG_RX_FULL] = copy;
    // while a condition still stands its flag refuses the clear
    rhold = rset;
  end

  // only the ones written clear; zeros leave flags alone
  wire [7:0] rclr = (rx_flag_clr_wr && reg_run) ? rx_flag_clr_data & ~rhold : 8'h00;
  // a set in the clearing cycle wins
  wire [7:0] next_rx_flag = (rx_flag_reg & ~rclr) | rset;

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_flag_reg <= RFLG_RESET;
    end else if (clk_en) begin
      rx_flag_reg <= next_rx_flag;
    end
  end

  // clearing an empty flag schedules that buffer; completion sets it again
  wire [2:0] tclr = reg_run ? tx_flag_clr : 3'h0;
  wire [2:0] next_tx_flag = (tx_flag_reg & ~tclr) | tx_done;

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_flag_reg <= TFLG_RESET;
    end else if (clk_en) begin
      tx_flag_reg <= next_tx_flag;
    end
  end

  // ==========================================================================
  // interrupt vectors
  // ==========================================================================
  wire [5:0] err_flags = {
    rx_flag_reg[RFLG_RX_WARN],
    rx_flag_reg[RFLG_TX_WARN],
    rx_flag_reg[RFLG_RX_PASSIVE],
    rx_flag_reg[RFLG_TX_PASSIVE],
    rx_flag_reg[RFLG_BUS_OFF],
    rx_flag_reg[RFLG_OVERRUN]
  };
  wire gate = !global_irq_mask;

  // levels: pending exactly as long as an enabled flag stays set and global_irq_mask is low, and for wake sleep_ack is high
  assign irq_wake = gate && rx_flag_reg[RFLG_WAKE] && wake_irq_en && sleep_ack;
  assign irq_err = gate && |(err_flags & err_irq_en);
  assign irq_rx = gate && rx_full && rx_full_irq_en;
  assign irq_tx = gate && |(tx_flag_reg & tx_empty_irq_en);

  // ==========================================================================
  // transmit pin
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      can_tx_pin <= RECESSIVE;
    end else if (clk_en) begin
      can_tx_pin <= core_run ? tx_bit : RECESSIVE;
    end
  end

endmodule : cif_can_id_filter

// ### tb/cif_monitor.sv
// Concurrent checks on the ports of the identifier filter top module.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/10ps
module cif_monitor
  import cif_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic cpu_stop,
  input wire logic sleep_ack,
  input wire logic soft_reset_lock,
  input wire logic global_irq_mask,
  input wire logic bus_activity,
  input wire logic [ERR_CNT_W-1:0] rx_err_cnt,
  input wire logic [ERR_CNT_W-1:0] tx_err_cnt,
  input wire logic can_tx_pin,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_sel,
  input wire logic [7:0] bit_timing_zero,
  input wire logic rx_flag_clr_wr,
  input wire logic [7:0] rx_flag_clr_data,
  input wire logic [7:0] rx_flag_reg,
  input wire logic rx_full_irq_en,
  input wire logic irq_rx,
  input wire cif_mode_e can_mode,
  input wire logic core_clk_run,
  input wire logic reg_clk_run,
  input wire logic bus_off_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_warn_clear;
    clk_en && rx_flag_clr_wr && rx_flag_clr_data[RFLG_RX_WARN] && rx_err_cnt >= WARN_LIMIT;
  endsequence
  sequence s_bus_wake;
    clk_en && bus_activity && sleep_ack && !soft_reset_lock && !cpu_stop;
  endsequence
  AST_IRQ_RX: assert property (irq_rx == (rx_flag_reg[RFLG_RX_FULL] && rx_full_irq_en && !global_irq_mask))
    else $error("receive vector mismatch");
  AST_WAKE_SET: assert property (s_bus_wake |=> rx_flag_reg[RFLG_WAKE])
    else $error("wake flag not set");
  AST_MODE_PD: assert property (cpu_stop |-> can_mode == CIF_POWER_DOWN)
    else $error("stop not decoded");
  AST_CLOCKS: assert property (can_mode != CIF_NORMAL |-> !core_clk_run && (reg_clk_run == (can_mode != CIF_POWER_DOWN)))
    else $error("clock run wrong");
  AST_TX_PIN: assert property (clk_en && can_mode != CIF_NORMAL |=> can_tx_pin == RECESSIVE)
    else $error("tx pin not recessive");
  AST_WARN: assert property (clk_en && rx_err_cnt >= WARN_LIMIT |=> rx_flag_reg[RFLG_RX_WARN])
    else $error("warning flag missing");
  AST_CLR_HELD: assert property (s_warn_clear |=> rx_flag_reg[RFLG_RX_WARN])
    else $error("flag cleared under cause");
  AST_BUS_OFF: assert property (clk_en && tx_err_cnt > BUS_OFF_LIMIT |=> bus_off_state && rx_flag_reg[RFLG_BUS_OFF])
    else $error("bus off missing");
  AST_CFG_LOCK: assert property (clk_en && cfg_wr && cfg_sel == CFG_BIT_TIMING_ZERO && !soft_reset_lock |=> $stable(bit_timing_zero))
    else $error("locked write took effect");
endmodule : cif_monitor

bind cif_can_id_filter cif_monitor cif_monitor_i (.clk, .reset, .clk_en, .cpu_stop, .sleep_ack,
  .soft_reset_lock, .global_irq_mask, .bus_activity, .rx_err_cnt, .tx_err_cnt, .can_tx_pin, .cfg_wr,
  .cfg_sel, .bit_timing_zero, .rx_flag_clr_wr, .rx_flag_clr_data, .rx_flag_reg, .rx_full_irq_en,
  .irq_rx, .can_mode, .core_clk_run, .reg_clk_run, .bus_off_state);

// ### tb/cif_frame_src.sv
// Protocol engine stand-in: offers received frames at the filter input.
// Assumes the caller is just past a rising clock edge.
`timescale 1ns/10ps
module cif_frame_src
  import cif_pkg::*;
(
  input wire logic clk,
  input wire logic ready,
  output logic valid,
  output logic [ID_W-1:0] id,
  output logic [63:0] data,
  output logic own
);
  initial begin
    valid = 1'b0; id = '0; data = '0; own = 1'b0;
  end
  // held until taken, or withdrawn after 40 refused edges
  task automatic send(input logic [ID_W-1:0] fid, input logic fown, input int gap, output logic ok);
    int n;
    n = 0;
    repeat (gap) @(posedge clk);
    #1;
    valid = 1'b1; id = fid; data = {fid, ~fid}; own = fown;
    // ready is read before the edge: the push itself may drop it
    do begin
      ok = ready;
      @(posedge clk);
      n++;
    end while (!ok && n < 40);
    #1;
    // junk once released
    valid = 1'b0; id = ~fid; data = ~data; own = ~fown;
  endtask : send
endmodule : cif_frame_src

// ### tb/cif_can_id_filter_test.sv
// Self-checking bench for the identifier filter block.
// Assumes design sources and the monitor are compiled beforehand.
`timescale 1ns/10ps
module cif_can_id_filter_test;
  import cif_pkg::*;
  logic clk, reset, clk_en, rx_in_valid, rx_in_ready, rx_in_own, cpu_stop, sleep_ack;
  logic soft_reset_lock, global_irq_mask, bus_activity, tx_bit, can_tx_pin, cfg_wr;
  logic rx_flag_clr_wr, wake_irq_en, rx_full_irq_en, irq_wake, irq_err, irq_rx, irq_tx;
  logic core_clk_run, reg_clk_run, rx_passive_state, tx_passive_state, bus_off_state;
  logic [ID_W-1:0] rx_in_id, rx_front_id, id_pattern_regs, id_dontcare_regs;
  logic [63:0] rx_in_data, rx_front_data;
  logic [1:0] filter_hit_index;
  logic [ERR_CNT_W-1:0] rx_err_cnt, tx_err_cnt;
  logic [2:0] tx_done, tx_flag_clr, tx_flag_reg, tx_empty_irq_en;
  logic [3:0] cfg_sel;
  logic [7:0] cfg_wdata, module_ctrl_one, bit_timing_zero, bit_timing_one, filter_control_reg;
  logic [7:0] rx_flag_clr_data, rx_flag_reg;
  logic [5:0] err_irq_en;
  cif_mode_e can_mode;
  int err_count, checks;
  cif_can_id_filter #(.DATA_W(64), .FIFO_DEPTH(8)) cif_can_id_filter_i (.*);
  cif_frame_src cif_frame_src_i (.clk(clk), .ready(rx_in_ready), .valid(rx_in_valid),
    .id(rx_in_id), .data(rx_in_data), .own(rx_in_own));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cfg(input logic [3:0] s, input logic [7:0] v);
    cfg_wr = 1'b1; cfg_sel = s; cfg_wdata = v;
    tick(1);
    cfg_wr = 1'b0;
    tick(1);
  endtask : cfg
  // only the bits meant for clearing are written as one
  task automatic clr(input logic [7:0] m);
    rx_flag_clr_data = m; rx_flag_clr_wr = 1'b1;
    tick(1);
    rx_flag_clr_wr = 1'b0;
    tick(1);
  endtask : clr
  task automatic snd(input logic [31:0] fid, input int gap);
    logic ok;
    cif_frame_src_i.send(fid, 1'b0, gap, ok);
    tick(4);
  endtask : snd
  task automatic bank(input logic [7:0] mode, input logic [31:0] pat, input logic [31:0] dc);
    soft_reset_lock = 1'b1;
    cfg(CFG_FILTER_CONTROL, mode);
    for (int k = 0; k < 4; k++) begin
      cfg(CFG_PATTERN_BASE + 4'(k), pat[31-8*k -: 8]);
      cfg(CFG_DONTCARE_BASE + 4'(k), dc[31-8*k -: 8]);
    end
    soft_reset_lock = 1'b0;
    tick(1);
  endtask : bank
  task automatic t_lock;
    chk("tflg", tx_flag_reg, 3'h7);
    chk("rflg", rx_flag_reg, 8'h00);
    cfg(CFG_BIT_TIMING_ZERO, 8'hAA);
    chk("btz", bit_timing_zero, 8'h00);
    soft_reset_lock = 1'b1;
    cfg(CFG_BIT_TIMING_ZERO, 8'hAA);
    chk("btz", bit_timing_zero, 8'hAA);
    soft_reset_lock = 1'b0;
  endtask : t_lock
  task automatic t_quad;
    bank(8'h20, 32'h1122_3344, 32'h0000_00FF);
    chk("bank", {id_pattern_regs, id_dontcare_regs}, 64'h1122_3344_0000_00FF);
    snd(32'h335A_5A5A, 1);
    chk("fctl", filter_control_reg, 8'h22);
    chk("hit", filter_hit_index, 2'h2);
    chk("rxf", rx_flag_reg, 8'h01);
    chk("irq_rx", irq_rx, 1'b1);
    global_irq_mask = 1'b1;
    tick(1);
    chk("masked", irq_rx, 1'b0);
    global_irq_mask = 1'b0;
    snd(32'h2200_0001, 0);
    chk("front", rx_front_id, 32'h335A_5A5A);
    snd(32'h4400_0002, 0);
    chk("ovr", rx_flag_reg, 8'h03);
    chk("irq_err", irq_err, 1'b1);
    clr(8'h02);
    chk("ovr clr", rx_flag_reg, 8'h01);
    clr(8'h01);
    tick(2);
    chk("front2", rx_front_id, 32'h2200_0001);
    chk("rxf2", rx_flag_reg, 8'h01);
    clr(8'h01);
  endtask : t_quad
  task automatic t_single;
    bank(8'h00, 32'h1234_5678, 32'h0000_000F);
    snd(32'h1234_5671, 0);
    chk("hit0", {filter_hit_index, rx_flag_reg}, 10'h001);
    clr(8'h01);
    snd(32'h1234_5778, 0);
    chk("miss", rx_flag_reg, 8'h00);
    bank(8'h30, 32'h1234_5678, 32'h0);
    snd(32'h1234_5678, 0);
    chk("closed", rx_flag_reg, 8'h00);
  endtask : t_single
  task automatic t_fill_wake;
    logic ok;
    sleep_ack = 1'b1;
    wake_irq_en = 1'b1;
    tick(2);
    chk("slp", {can_mode, can_tx_pin, core_clk_run, reg_clk_run}, 5'b01101);
    for (int k = 0; k < 9; k++) begin
      cif_frame_src_i.send(32'h1234_5678, 1'b0, 0, ok);
      chk("push", ok, k < 8);
    end
    chk("full", rx_in_ready, 1'b0);
    bus_activity = 1'b1;
    tick(1);
    bus_activity = 1'b0;
    tick(1);
    chk("wake", {rx_flag_reg[RFLG_WAKE], irq_wake}, 2'b11);
    clr(8'h80);
    chk("wake clr", rx_flag_reg, 8'h00);
    sleep_ack = 1'b0;
    tick(12);
    chk("drain", {rx_in_ready, rx_flag_reg}, 9'h100);
  endtask : t_fill_wake
  task automatic t_modes;
    cif_mode_e m;
    tx_bit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      {cpu_stop, sleep_ack, soft_reset_lock} = 3'(i);
      tick(2);
      m = i[2] ? CIF_POWER_DOWN : (i[0] ? CIF_SOFT_RESET : (i[1] ? CIF_SLEEP : CIF_NORMAL));
      chk("mode", can_mode, m);
      chk("pin", can_tx_pin, m != CIF_NORMAL);
    end
    {cpu_stop, sleep_ack, soft_reset_lock} = 3'h0;
    tx_bit = 1'b1;
    tick(2);
  endtask : t_modes
  task automatic t_err;
    logic [8:0] rx[4] = '{9'd95, 9'd96, 9'd127, 9'd128};
    logic [8:0] tx[4] = '{9'd0, 9'd0, 9'd255, 9'd256};
    logic [7:0] ex[4] = '{8'h00, 8'h40, 8'h68, 8'h7C};
    err_irq_en = 6'h3F;
    for (int k = 0; k < 4; k++) begin
      rx_err_cnt = rx[k]; tx_err_cnt = tx[k];
      tick(2);
      chk("eflg", rx_flag_reg & 8'h7C, ex[k]);
    end
    chk("states", {rx_passive_state, tx_passive_state, bus_off_state, irq_err}, 4'hF);
    clr(8'h7C);
    chk("held", rx_flag_reg & 8'h7C, 8'h7C);
    rx_err_cnt = '0; tx_err_cnt = '0;
    tick(1);
    clr(8'h7C);
    chk("cleared", rx_flag_reg, 8'h00);
  endtask : t_err
  task automatic t_tx;
    tx_empty_irq_en = 3'b010;
    tick(1);
    chk("irq_tx", irq_tx, 1'b1);
    tx_flag_clr = 3'b010;
    tick(1);
    tx_flag_clr = 3'b000;
    tick(1);
    chk("sched", {tx_flag_reg, irq_tx}, 4'b1010);
    tx_done = 3'b010;
    tick(1);
    tx_done = 3'b000;
    tick(1);
    chk("sent", {tx_flag_reg, irq_tx}, 4'b1111);
    clk_en = 1'b0;
    tx_flag_clr = 3'b111;
    tick(2);
    chk("frozen", tx_flag_reg, 3'h7);
    clk_en = 1'b1;
    tx_flag_clr = 3'b000;
    tick(1);
  endtask : t_tx
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  initial begin
    reset = 1'b1; clk_en = 1'b1; cpu_stop = 1'b0; sleep_ack = 1'b0; soft_reset_lock = 1'b0;
    global_irq_mask = 1'b0; bus_activity = 1'b0; tx_bit = 1'b1; cfg_wr = 1'b0; cfg_sel = '0;
    cfg_wdata = '0; rx_flag_clr_wr = 1'b0; rx_flag_clr_data = '0; wake_irq_en = 1'b0;
    rx_full_irq_en = 1'b1; err_irq_en = 6'h01; tx_empty_irq_en = '0; rx_err_cnt = '0;
    tx_err_cnt = '0; tx_done = '0; tx_flag_clr = '0; err_count = 0; checks = 0;
    tick(10);
    reset = 1'b0;
    t_lock();
    t_quad();
    t_single();
    t_fill_wake();
    t_modes();
    t_err();
    t_tx();
    end_sim();
  end
endmodule : cif_can_id_filter_test
